// [hdl/tss_top.sv]
// Trigger and sample sequencer with APB register slave
// Behaviour
// - Sources: auto, outside pin, bus command
// - Bulk mode accepts auto source only
// - Bulk log-stop on pin enables pin
// - Settings locked and error while running
// - Remote: pin used only with pin source
// - Local: panel menu decides pin use
// - One slope setting for both modes
// - Trigger count 1..50000, endless runs forever
// - Out-of-range values clamp, raise error
// - Trigger count used in remote only
// - Bulk ignores counts and delay
// - Endless count reads back as NaN
// - Delay 0..3600 s in 10 us steps
// - Finer times round up one step
// - Slope picks rising or falling edge
// - Samples per trigger 1..100000
// - Interval 0..3600 s in 10 us steps
// - Configure stops measurement
// - Remote to local forces stop
// - Configure restores default settings; slope keeps its value here
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tss_map.svh"
module tss_top
  import tss_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        ext_trig_in,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             sample_strobe,
  output logic             measure_active,
  output logic             exec_error,
  output logic             ext_input_enable
);
  // ----------------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------------
  // Clamp a count to 1..max; top bit flags a clamp
  function automatic logic [17:0] tss_clamp_cnt(input logic [31:0] v,
                                                input logic [16:0] max);
    if (v == 32'h0000_0000) tss_clamp_cnt = {1'b1, 17'h0_0001};
    else if (v > {15'h0000, max}) tss_clamp_cnt = {1'b1, max};
    else tss_clamp_cnt = {1'b0, v[16:0]};
  endfunction

  // Microseconds to 10 us steps, clamped to the limit; top bit flags a clamp
  function automatic logic [29:0] tss_time_steps(input logic [31:0] v);
    logic        over;
    logic [32:0] lim;
    logic [32:0] q;
    over = (v > `TSS_MAX_TIME_US);
    lim  = over ? {1'b0, `TSS_MAX_TIME_US} : {1'b0, v};
    q    = (lim + `TSS_ROUND_ADD) / `TSS_STEP_US;
    tss_time_steps = {over, q[28:0]};
  endfunction

  // ----------------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------------
  tss_state_type state_q, state_d;   // Sequencer state
  tss_src_type   src_q;              // Programmed trigger source
  logic        fall_q;               // Falling edge select
  logic        remote_q;             // Remote mode
  logic        bulk_q;               // Bulk mode
  logic        logext_q;             // Bulk log stop event is the pin
  logic        panel_q;              // Panel outside trigger menu on
  logic        endless_q;            // Endless trigger count
  logic [15:0] tcount_q;             // Trigger count
  logic [16:0] scount_q;             // Sample count
  logic [28:0] delay_q;              // Trigger delay in steps
  logic [28:0] intv_q;               // Sample interval in steps
  logic [15:0] tleft_q, tleft_d;     // Triggers still to serve
  logic [16:0] sleft_q, sleft_d;     // Samples still to take
  logic        err_q;                // Sticky execution error

  // ----------------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------------
  wire wr      = psel & penable & pready & pwrite;
  wire hit_ctl = (paddr == `TSS_OFF_CTRL);
  wire hit_mod = (paddr == `TSS_OFF_MODE);
  wire hit_src = (paddr == `TSS_OFF_SRC);
  wire hit_tc  = (paddr == `TSS_OFF_TCOUNT);
  wire hit_dl  = (paddr == `TSS_OFF_TDELAY);
  wire hit_sc  = (paddr == `TSS_OFF_SCOUNT);
  wire hit_iv  = (paddr == `TSS_OFF_SINTV);
  wire hit_st  = (paddr == `TSS_OFF_STATUS);
  wire mapped  = hit_ctl | hit_mod | hit_src | hit_tc | hit_dl | hit_sc | hit_iv | hit_st;
  wire busy    = (state_q != TSS_ST_STOP);
  wire wr_set  = wr & (hit_src | hit_tc | hit_dl | hit_sc | hit_iv);
  wire locked  = wr_set & busy;
  wire take    = wr_set & ~busy;

  // Control strobes
  wire do_init   = wr & hit_ctl & pwdata[`TSS_CTRL_INIT];
  wire do_abort  = wr & hit_ctl & pwdata[`TSS_CTRL_ABORT];
  wire do_conf   = wr & hit_ctl & pwdata[`TSS_CTRL_CONF];
  wire do_bustrg = wr & hit_ctl & pwdata[`TSS_CTRL_BUSTRG];
  wire wr_mode   = wr & hit_mod;
  wire go_local  = wr_mode & remote_q & ~pwdata[`TSS_MODE_REMOTE];

  // ----------------------------------------------------------------------------
  // Setting checks
  // ----------------------------------------------------------------------------
  wire [1:0]  src_wr   = pwdata[1:0];
  wire        src_bad  = (src_wr == 2'h3) ||
                         (bulk_q && (src_wr != TSS_AUTO_TRIGGER_SOURCE));
  wire [17:0] tc_chk   = tss_clamp_cnt({1'b0, pwdata[30:0]}, `TSS_MAX_TCOUNT);
  wire [17:0] sc_chk   = tss_clamp_cnt(pwdata, `TSS_MAX_SCOUNT);
  wire [29:0] dl_chk   = tss_time_steps(pwdata);
  wire [29:0] iv_chk   = tss_time_steps(pwdata);
  wire        tc_inf   = pwdata[`TSS_TC_ENDLESS];
  // Clamp errors count only when the value is taken
  wire        clamp_err = take & ((hit_tc & ~tc_inf & tc_chk[17]) |
                                  (hit_sc & sc_chk[17]) |
                                  (hit_dl & dl_chk[29]) |
                                  (hit_iv & iv_chk[29]));
  wire        src_err   = take & hit_src & src_bad;
  wire        err_set   = locked | clamp_err | src_err;
  wire        err_clr   = wr & hit_st & pwdata[`TSS_ST_ERR];

  // ----------------------------------------------------------------------------
  // Trigger selection
  // ----------------------------------------------------------------------------
  logic pin_edge;  // Qualified edge on the outside pin
  wire  src_auto = (src_q == TSS_AUTO_TRIGGER_SOURCE);
  wire  src_pin  = (src_q == TSS_OUTSIDE_PIN_TRIGGER_SOURCE);
  wire  src_bus  = (src_q == TSS_BUS_TRIGGER_SOURCE);
  // Pin use: bulk log stop, remote source, or local panel menu
  wire  pin_en   = bulk_q   ? logext_q :
                   remote_q ? src_pin  :
                              panel_q;
  // Bulk runs free on auto; local runs on auto unless the panel picks the pin
  wire  auto_go  = bulk_q   ? 1'b1 :
                   remote_q ? src_auto : ~panel_q;
  wire  trig     = auto_go |
                   (~bulk_q & pin_en & pin_edge) |
                   (~bulk_q & remote_q & src_bus & do_bustrg);

  tss_edge_det u_edge (
    .clk                 (clk),
    .resetn              (resetn),
    .pin                 (ext_trig_in),
    .falling_edge_select (fall_q),
    .edge_seen           (pin_edge)
  );

  // ----------------------------------------------------------------------------
  // Effective run settings
  // ----------------------------------------------------------------------------
  wire        eff_endless = bulk_q | ~remote_q | endless_q;
  wire [16:0] eff_scount  = bulk_q ? 17'h0_0001 : scount_q;
  wire [28:0] eff_delay   = bulk_q ? 29'h0000_0000 : delay_q;

  // ----------------------------------------------------------------------------
  // Step timer
  // ----------------------------------------------------------------------------
  tss_timer_if tif ();
  tss_step_timer u_timer (
    .clk    (clk),
    .resetn (resetn),
    .tif    (tif)
  );

  // ----------------------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------------------
  logic strobe_d;  // Sample strobe next value
  logic load_d;    // Timer load
  logic [28:0] steps_d;
  wire  force_stop = do_abort | do_conf | go_local;
  wire  last_smp   = (sleft_q <= 17'h0_0001);
  wire  more_trig  = eff_endless | (tleft_q > 16'h0001);

  always_comb begin
    state_d  = state_q;
    tleft_d  = tleft_q;
    sleft_d  = sleft_q;
    strobe_d = 1'b0;
    load_d   = 1'b0;
    steps_d  = 29'h0000_0000;
    case (state_q)
      TSS_ST_STOP: begin
        // Leave stop only on initiate
        if (do_init) begin
          state_d = TSS_ST_WAIT;
          tleft_d = tcount_q;
        end
      end
      TSS_ST_WAIT: begin
        // Trigger starts the delay
        if (trig) begin
          state_d = TSS_ST_DELAY;
          sleft_d = eff_scount;
          load_d  = 1'b1;
          steps_d = eff_delay;
        end
      end
      TSS_ST_DELAY: begin
        if (tif.done) state_d = TSS_ST_SAMPLE;
      end
      TSS_ST_SAMPLE: begin
        strobe_d = 1'b1;
        if (!last_smp) begin
          // More samples for this trigger after the interval
          state_d = TSS_ST_INTV;
          sleft_d = sleft_q - 17'h0_0001;
          load_d  = 1'b1;
          steps_d = intv_q;
        end else if (more_trig) begin
          // Rearm; endless leaves the count alone
          state_d = TSS_ST_WAIT;
          if (!eff_endless) tleft_d = tleft_q - 16'h0001;
        end else begin
          state_d = TSS_ST_STOP;
          tleft_d = 16'h0000;
        end
      end
      TSS_ST_INTV: begin
        if (tif.done) state_d = TSS_ST_SAMPLE;
      end
      default: state_d = TSS_ST_STOP;
    endcase
    // Stop wins over any step of the sequence
    if (force_stop) begin
      state_d  = TSS_ST_STOP;
      strobe_d = 1'b0;
    end
  end

  assign tif.load  = load_d;
  assign tif.steps = steps_d;

  // ----------------------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= TSS_ST_STOP;
      tleft_q <= 16'h0000;
      sleft_q <= 17'h0_0000;
    end else begin
      state_q <= state_d;
      tleft_q <= tleft_d;
      sleft_q <= sleft_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------------------
  // Mode bits stay writable while running so local can always be reached
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      remote_q <= 1'b0;
      bulk_q   <= 1'b0;
      logext_q <= 1'b0;
      panel_q  <= 1'b0;
    end else if (wr_mode) begin
      remote_q <= pwdata[`TSS_MODE_REMOTE];
      bulk_q   <= pwdata[`TSS_MODE_BULK];
      logext_q <= pwdata[`TSS_MODE_LOGEXT];
      panel_q  <= pwdata[`TSS_MODE_PANEL];
    end
  end

  // ----------------------------------------------------------------------------
  // Trigger and sample settings
  // ----------------------------------------------------------------------------
  // Configure restores defaults; slope is not among them
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      src_q     <= TSS_AUTO_TRIGGER_SOURCE;
      fall_q    <= 1'b0;
      endless_q <= 1'b0;
      tcount_q  <= `TSS_RST_TCOUNT;
      scount_q  <= `TSS_RST_SCOUNT;
      delay_q   <= `TSS_RST_TIME;
      intv_q    <= `TSS_RST_TIME;
    end else if (do_conf) begin
      src_q     <= TSS_AUTO_TRIGGER_SOURCE;
      endless_q <= 1'b0;
      tcount_q  <= `TSS_RST_TCOUNT;
      scount_q  <= `TSS_RST_SCOUNT;
      delay_q   <= `TSS_RST_TIME;
      intv_q    <= `TSS_RST_TIME;
    end else if (take) begin
      // Locked writes never get here
      if (hit_src && !src_bad) begin
        src_q  <= tss_src_type'(src_wr);
        fall_q <= pwdata[`TSS_SRC_FALL];
      end
      if (hit_src && src_bad) fall_q <= pwdata[`TSS_SRC_FALL];
      if (hit_tc) begin
        endless_q <= tc_inf;
        if (!tc_inf) tcount_q <= tc_chk[15:0];
      end
      if (hit_sc) scount_q <= sc_chk[16:0];
      if (hit_dl) delay_q <= dl_chk[28:0];
      if (hit_iv) intv_q <= iv_chk[28:0];
    end
  end

  // ----------------------------------------------------------------------------
  // Error flag
  // ----------------------------------------------------------------------------
  // A new error in the clearing cycle survives the clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) err_q <= 1'b0;
    else         err_q <= err_set | (err_q & ~err_clr);
  end

  // ----------------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------------
  wire [31:0] rd_tc = endless_q ? `TSS_NAN_CODE : {16'h0000, tcount_q};
  wire [31:0] rd_status = {9'h000, tleft_q, state_q, busy, err_q};
  wire [31:0] rd_val =
    hit_mod ? {28'h000_0000, panel_q, logext_q, bulk_q, remote_q} :
    hit_src ? {27'h000_0000, fall_q, 2'h0, src_q} :
    hit_tc  ? rd_tc :
    hit_dl  ? {3'h0, delay_q} :
    hit_sc  ? {15'h0000, scount_q} :
    hit_iv  ? {3'h0, intv_q} :
    hit_st  ? rd_status :
              32'h0000_0000;

  // ----------------------------------------------------------------------------
  // APB answer
  // ----------------------------------------------------------------------------
  // No wait state: data is latched in setup so prdata comes from a flop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel && !penable) prdata <= pwrite ? 32'h0000_0000 : rd_val;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sample_strobe    <= 1'b0;
      measure_active   <= 1'b0;
      exec_error       <= 1'b0;
      ext_input_enable <= 1'b0;
    end else begin
      sample_strobe    <= strobe_d;
      measure_active   <= (state_d != TSS_ST_STOP);
      exec_error       <= err_set | (err_q & ~err_clr);
      ext_input_enable <= pin_en;
    end
  end
endmodule // tss_top
`default_nettype wire

// [hdl/tss_map.svh]
// Register offsets, field positions, reset values and timing counts of the sequencer
`ifndef TSS_MAP_SVH
`define TSS_MAP_SVH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define TSS_OFF_CTRL     8'h00
`define TSS_OFF_MODE     8'h04
`define TSS_OFF_SRC      8'h08
`define TSS_OFF_TCOUNT   8'h0C
`define TSS_OFF_TDELAY   8'h10
`define TSS_OFF_SCOUNT   8'h14
`define TSS_OFF_SINTV    8'h18
`define TSS_OFF_STATUS   8'h1C
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define TSS_CTRL_INIT    0
`define TSS_CTRL_ABORT   1
`define TSS_CTRL_CONF    2
`define TSS_CTRL_BUSTRG  3
`define TSS_MODE_REMOTE  0
`define TSS_MODE_BULK    1
`define TSS_MODE_LOGEXT  2
`define TSS_MODE_PANEL   3
`define TSS_SRC_FALL     4
`define TSS_TC_ENDLESS   31
`define TSS_ST_ERR       0
`define TSS_ST_BUSY      1
// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define TSS_RST_TCOUNT   16'h0001
`define TSS_RST_SCOUNT   17'h0_0001
`define TSS_RST_TIME     29'h0000_0000
`define TSS_MAX_TCOUNT   17'h0_C350
`define TSS_MAX_SCOUNT   17'h1_86A0
`define TSS_MAX_TIME_US  32'hD693_A400
`define TSS_NAN_CODE     32'h7E95_1CF0
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TSS_STEP_US      33'h0_0000_000A
`define TSS_ROUND_ADD    33'h0_0000_0009
`define TSS_STEP_NS      10000
`define TSS_CLK_NS       20
`define TSS_STEP_CYC     (`TSS_STEP_NS / `TSS_CLK_NS)
`endif

// [hdl/tss_pkg.sv]
// Types shared by the sequencer modules
`default_nettype none
package tss_pkg;
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    TSS_ST_STOP   = 5'b00001,
    TSS_ST_WAIT   = 5'b00010,
    TSS_ST_DELAY  = 5'b00100,
    TSS_ST_SAMPLE = 5'b01000,
    TSS_ST_INTV   = 5'b10000
  } tss_state_type;
  // Trigger source codes
  typedef enum logic [1:0] {
    TSS_AUTO_TRIGGER_SOURCE        = 2'h0,
    TSS_OUTSIDE_PIN_TRIGGER_SOURCE = 2'h1,
    TSS_BUS_TRIGGER_SOURCE         = 2'h2
  } tss_src_type;
endpackage
`default_nettype wire

// [hdl/tss_timer_if.sv]
// Handshake between sequencer control and its step timer
`timescale 1ns/1ps
`default_nettype none
interface tss_timer_if;
  logic        load;   // Start a new wait
  logic [28:0] steps;  // Wait length in 10 us steps
  logic        done;   // Wait has elapsed
  modport ctl (output load, output steps, input done);
  modport tmr (input load, input steps, output done);
endinterface
`default_nettype wire

// [hdl/tss_step_timer.sv]
// Step timer that counts 10 us steps for delay and interval waits
`timescale 1ns/1ps
`default_nettype none
`include "tss_map.svh"
module tss_step_timer
  import tss_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  tss_timer_if.tmr tif
);
  localparam logic [8:0] STEP_LAST = 9'(`TSS_STEP_CYC - 1);
  logic [8:0]  pre_q;     // Cycle prescaler within one step
  logic [28:0] rem_q;     // Steps still to run
  logic        run_q;     // Wait in progress
  wire         step_end = (pre_q == STEP_LAST);

  assign tif.done = ~run_q;

  // ----------------------------------------------------------------------------
  // Count down
  // ----------------------------------------------------------------------------
  // A zero-length load finishes at once, so a zero delay costs one cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_q <= 9'h000;
      rem_q <= 29'h0000_0000;
      run_q <= 1'b0;
    end else if (tif.load) begin
      pre_q <= 9'h000;
      rem_q <= tif.steps;
      run_q <= (tif.steps != 29'h0000_0000);
    end else if (run_q) begin
      pre_q <= step_end ? 9'h000 : pre_q + 9'h001;
      if (step_end) begin
        rem_q <= rem_q - 29'h0000_0001;
        run_q <= (rem_q != 29'h0000_0001);
      end
    end
  end
endmodule // tss_step_timer
`default_nettype wire

// [hdl/tss_edge_det.sv]
// Edge detector for the outside trigger pin
`timescale 1ns/1ps
`default_nettype none
module tss_edge_det
  import tss_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pin,
  input  wire logic falling_edge_select,
  output logic      edge_seen
);
  logic prev_q;  // Pin level one cycle back
  // Idle level high so a pin held high at reset is not a rise
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) prev_q <= 1'b1;
    else         prev_q <= pin;
  end
  // Rising or falling edge by the one shared slope select
  assign edge_seen = falling_edge_select ? (prev_q & ~pin) : (~prev_q & pin);
endmodule // tss_edge_det
`default_nettype wire

// [test/tss_top_properties.sv]
// Port checker of the trigger and sample sequencer
`timescale 1ns/1ps
`default_nettype none
module tss_top_properties (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        sample_strobe,
  input wire logic        measure_active,
  input wire logic        exec_error,
  input wire logic        ext_input_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Completed write, and a write to the control word
  wire wr  = psel & penable & pready & pwrite;
  wire ctl = wr && paddr == 8'h00;
  AST_RDY: assert property (psel && !penable |=> pready) else $error("no ready");
  AST_ONE: assert property (pready |=> !pready) else $error("ready held");
  AST_DEC: assert property (pready && paddr > 8'h1C |-> pslverr) else $error("no slverr");
  AST_INIT: assert property (ctl && pwdata[2:0] == 3'b001 |-> ##[1:2] measure_active)
    else $error("no start");
  AST_CONF: assert property (ctl && pwdata[2] |-> ##2 !measure_active)
    else $error("no stop");
  AST_LOCK: assert property (wr && paddr inside {[8'h08:8'h18]} && measure_active
    |-> ##[1:2] exec_error) else $error("no lock error");
  AST_CLMP: assert property (wr && paddr == 8'h0C && pwdata == 0 |-> ##[1:2] exec_error)
    else $error("no clamp error");
  AST_STRB: assert property (sample_strobe |-> $past(measure_active))
    else $error("idle strobe");
  AST_EXT: assert property (wr && paddr == 8'h04 && pwdata[2:1] == 2'b11
    |-> ##[1:2] ext_input_enable) else $error("pin not enabled");
  cover property (sample_strobe);
  cover property (ctl && pwdata[2]);
  cover property (pready && pslverr);
endmodule // tss_top_properties
bind tss_top tss_top_properties u_props (.clk(clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .sample_strobe(sample_strobe), .measure_active(measure_active),
  .exec_error(exec_error), .ext_input_enable(ext_input_enable));
`default_nettype wire

// [test/tss_top_tb.sv]
// Self-checking bench of the trigger and sample sequencer
`timescale 1ns/1ps
`default_nettype none
module tss_top_tb;
  logic        clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, ext_trig_in = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, sample_strobe, measure_active, exec_error, ext_input_enable;
  logic        slv;
  int          n_errors = 0, num_checks = 0, cyc = 0, n_strobe = 0, s0, v;
  int          seed = 32'hff89;
  always #10 clk = ~clk;
  // Strobe tally and hang guard; the longest run is a few thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    n_strobe <= n_strobe + (sample_strobe === 1'b1);
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      final_report();
    end
  end
  tss_top u_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .ext_trig_in(ext_trig_in),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .sample_strobe(sample_strobe),
    .measure_active(measure_active), .exec_error(exec_error),
    .ext_input_enable(ext_input_enable));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Ends once pready is high; the bench timeout catches a hang
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 0);
    chk(nm, rd, e);
  endtask
  // Microseconds to whole 10 us steps, partial steps counted up
  function automatic logic [31:0] steps(input logic [31:0] us);
    return (us + 9) / 10;
  endfunction
  // Extra edge lets the strobe tally take the last pulse
  task automatic idle();
    while (measure_active !== 1'b0) @(posedge clk);
    @(posedge clk);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    rdchk("tcount", 8'h0C, 1);
    rdchk("scount", 8'h14, 1);
    rdchk("src", 8'h08, 0);
    apb(1'b0, 8'h20, 0);
    chk("unmapped", slv, 1);
    wr(8'h0C, 0);
    rdchk("tc low", 8'h0C, 1);
    chk("clamp err", exec_error, 1);
    wr(8'h14, 32'h0003_0D40);
    rdchk("sc high", 8'h14, 32'h0001_86A0);
    wr(8'h0C, 32'h8000_0000);
    rdchk("endless", 8'h0C, 32'h7E95_1CF0);
    wr(8'h10, 32'hFFFF_FFFF);
    rdchk("dly max", 8'h10, 32'h1575_2A00);
    for (int i = 0; i < 4; i++) begin
      v = $random(seed) & 32'h000F_FFFF;
      wr(i[0] ? 8'h18 : 8'h10, v);
      rdchk("time", i[0] ? 8'h18 : 8'h10, steps(v));
    end
    // Configure brings back the defaults
    wr(8'h00, 4);
    rdchk("cfg dly", 8'h10, 0);
    rdchk("cfg tc", 8'h0C, 1);
    // Remote run: two triggers of three samples, 10 us apart
    wr(8'h04, 1);
    wr(8'h14, 3);
    wr(8'h0C, 2);
    wr(8'h18, 10);
    wr(8'h1C, 1);
    s0 = n_strobe;
    wr(8'h00, 1);
    wr(8'h14, 5);
    rdchk("locked", 8'h14, 3);
    chk("lock err", exec_error, 1);
    idle();
    chk("strobes", n_strobe - s0, 6);
    wr(8'h0C, 1);
    wr(8'h14, 1);
    // Wrong pin edge first, then the selected one
    for (int f = 0; f < 2; f++) begin
      ext_trig_in <= !f;
      wr(8'h08, 1 + 16 * f);
      s0 = n_strobe;
      wr(8'h00, 1);
      ext_trig_in <= f;
      repeat (12) @(posedge clk);
      chk("wrong edge", n_strobe - s0, 0);
      ext_trig_in <= !f;
      repeat (12) @(posedge clk);
      chk("edge", n_strobe - s0, 1);
    end
    wr(8'h08, 2);
    s0 = n_strobe;
    wr(8'h00, 1);
    ext_trig_in <= 1'b1;
    repeat (12) @(posedge clk);
    chk("pin ignored", n_strobe - s0, 0);
    wr(8'h00, 8);
    repeat (12) @(posedge clk);
    chk("bus trig", n_strobe - s0, 1);
    wr(8'h08, 1);
    wr(8'h00, 1);
    wr(8'h04, 0);
    repeat (2) @(posedge clk);
    chk("to local", measure_active, 0);
    s0 = n_strobe;
    wr(8'h00, 1);
    repeat (50) @(posedge clk);
    chk("local run", n_strobe - s0 > 2, 1);
    wr(8'h00, 2);
    idle();
    wr(8'h1C, 1);
    wr(8'h04, 7);
    wr(8'h08, 2);
    rdchk("bulk src", 8'h08, 1);
    chk("bulk err", exec_error, 1);
    chk("pin on", ext_input_enable, 1);
    final_report();
  end
endmodule // tss_top_tb
`default_nettype wire
